/* File: shared/icoi_pkg.sv */
// Constants and types shared by the inter-node cache operation issue block.
`default_nettype none
package icoi_pkg;
    localparam int INSN_W    = 32;
    localparam int GR_W      = 64;
    localparam int PADDR_W   = 40;
    localparam int LINE_OFS_W = 5;
    localparam int NUM_PROC  = 4;
    localparam int PROC_W    = 2;
    localparam int SPACE_W   = 3;

    localparam int OPC_MSB   = 31;
    localparam int OPC_LSB   = 26;
    localparam int SUB_MSB   = 20;
    localparam int SUB_LSB   = 16;
    localparam int S_MSB     = 15;
    localparam int S_LSB     = 14;
    localparam int K_MSB     = 13;
    localparam int K_LSB     = 12;
    localparam int H_MSB     = 11;
    localparam int H_LSB     = 10;
    localparam int BASE_SP_MSB = 63;
    localparam int BASE_SP_LSB = 62;

    localparam logic [5:0] MAJOR_OPC     = 6'h01;
    localparam logic [4:0] SUB_FLUSH     = 5'h02;
    localparam logic [4:0] SUB_PREF_SH   = 5'h04;
    localparam logic [4:0] SUB_PREF_EX   = 5'h06;
    localparam logic [1:0] FIXED_K_FIELD = 2'h3;
    localparam logic [1:0] HINT_NOCHK    = 2'h1;
    localparam logic [1:0] HINT_RD       = 2'h2;
    localparam logic [1:0] HINT_RDWR     = 2'h3;
    localparam logic [1:0] S_FROM_BASE   = 2'h0;

    localparam int CTX_ARMED_BIT = 63;
    localparam int CTX_TRIG_BIT  = 62;

    localparam logic [1:0] CSR_SEL_CTX     = 2'h0;
    localparam logic [1:0] CSR_SEL_FLUSH   = 2'h1;
    localparam logic [1:0] CSR_SEL_PREF_SH = 2'h2;
    localparam logic [1:0] CSR_SEL_PREF_EX = 2'h3;

    typedef enum logic [1:0] {
        ICOI_OP_NONE,
        ICOI_OP_FLUSH,
        ICOI_OP_PREF_SH,
        ICOI_OP_PREF_EX
    } icoi_op_t;
endpackage : icoi_pkg
`default_nettype wire

/* File: shared/icoi_link_if.sv */
// Decode results and context-register signals passed between block modules.
`timescale 1ns/1ps
`default_nettype none
interface icoi_link_if;
    import icoi_pkg::*;
    icoi_op_t           op;
    logic               is_op;
    logic               hint_ok;
    logic               chk_rd;
    logic               chk_wr;
    logic               spec_ok;
    logic [SPACE_W-1:0] space_sel;
    logic               sw_wr;
    logic [PROC_W-1:0]  sw_proc;
    logic               sw_armed;
    logic               sw_trig;
    logic               op_wr;
    logic [PROC_W-1:0]  op_proc;
    logic               tlb_inval;
    logic [NUM_PROC-1:0] armed;
    logic [NUM_PROC-1:0] trig;
    logic               issue;

    modport dec_src (output op, is_op, hint_ok, chk_rd, chk_wr, spec_ok,
                     space_sel);
    modport ctx_side (input sw_wr, sw_proc, sw_armed, sw_trig, op_wr,
                      op_proc, tlb_inval, output armed, trig, issue);
    modport top_side (input op, is_op, hint_ok, chk_rd, chk_wr, spec_ok,
                      space_sel, armed, trig, issue,
                      output sw_wr, sw_proc, sw_armed, sw_trig, op_wr,
                      op_proc, tlb_inval);
endinterface : icoi_link_if
`default_nettype wire

/* File: rtl/icoi_insn_decode.sv */
// Field decoder for the three inter-node cache operation instructions.
`timescale 1ns/1ps
`default_nettype none
module icoi_insn_decode
    import icoi_pkg::*;
(
    input  wire logic [INSN_W-1:0] insn_i,
    input  wire logic [1:0]        base_space_i,
    icoi_link_if.dec_src           dec
);
    function automatic icoi_op_t sub_to_op(input logic [4:0] sub);
        if (sub == SUB_FLUSH) begin
            return ICOI_OP_FLUSH;
        end else if (sub == SUB_PREF_SH) begin
            return ICOI_OP_PREF_SH;
        end else if (sub == SUB_PREF_EX) begin
            return ICOI_OP_PREF_EX;
        end else begin
            return ICOI_OP_NONE;
        end
    endfunction : sub_to_op

    logic [1:0] hint;
    logic [1:0] s_fld;
    logic       is_flush;

    always_comb begin
        hint     = insn_i[H_MSB:H_LSB];
        s_fld    = insn_i[S_MSB:S_LSB];
        dec.op   = sub_to_op(insn_i[SUB_MSB:SUB_LSB]);
        is_flush = (dec.op == ICOI_OP_FLUSH);
        dec.is_op = (insn_i[OPC_MSB:OPC_LSB] == MAJOR_OPC)
                    && (insn_i[K_MSB:K_LSB] == FIXED_K_FIELD)
                    && (dec.op != ICOI_OP_NONE);
        // Hint values with no defined meaning are refused as illegal.
        dec.hint_ok = is_flush ? (hint != 2'h0)
                               : (hint == HINT_RD || hint == HINT_RDWR);
        // Flush hint 1 checks nothing; hint 2 reads; hint 3 reads and writes.
        dec.chk_rd = (hint == HINT_RD) || (hint == HINT_RDWR);
        dec.chk_wr = (hint == HINT_RDWR);
        dec.spec_ok = is_flush ? (hint == HINT_NOCHK || hint == HINT_RD)
                               : (hint == HINT_RD);
        // A zero space field takes the space register from the base value.
        dec.space_sel = (s_fld == S_FROM_BASE) ? {1'b1, base_space_i}
                                               : {1'b0, s_fld};
    end
endmodule : icoi_insn_decode
`default_nettype wire

/* File: rtl/icoi_ctx_regs.sv */
// Armed and triggered flags of the four per-processor operation contexts.
`timescale 1ns/1ps
`default_nettype none
module icoi_ctx_regs
    import icoi_pkg::*;
(
    input  wire logic      clk_sys_i,
    input  wire logic      rst_i,
    icoi_link_if.ctx_side  ctx
);
    logic [NUM_PROC-1:0] armed_reg;
    logic [NUM_PROC-1:0] trig_reg;

    assign ctx.armed = armed_reg;
    assign ctx.trig  = trig_reg;
    assign ctx.issue = ctx.op_wr && armed_reg[ctx.op_proc];

    genvar p;
    generate
        for (p = 0; p < NUM_PROC; p++) begin : g_ctx
            logic armed_next;
            logic trig_next;
            always_comb begin
                armed_next = armed_reg[p];
                trig_next  = trig_reg[p];
                if (ctx.op_wr && ctx.op_proc == PROC_W'(p)) begin
                    if (!armed_reg[p]) begin
                        trig_next = 1'b0;
                    end else if (!trig_reg[p]) begin
                        trig_next  = 1'b1;
                        armed_next = 1'b0;
                    end
                end
                // An invalidate leaves only the fully set pair standing.
                if (ctx.tlb_inval && !(armed_next && trig_next)) begin
                    armed_next = 1'b0;
                    trig_next  = 1'b0;
                end
                // Software writes the flags outright and wins the cycle.
                if (ctx.sw_wr && ctx.sw_proc == PROC_W'(p)) begin
                    armed_next = ctx.sw_armed;
                    trig_next  = ctx.sw_trig;
                end
            end
            always_ff @(posedge clk_sys_i) begin
                if (rst_i) begin
                    armed_reg[p] <= 1'b0;
                    trig_reg[p]  <= 1'b0;
                end else begin
                    armed_reg[p] <= armed_next;
                    trig_reg[p]  <= trig_next;
                end
            end
        end
    endgenerate

    property p_arm_trigger;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ctx.op_wr && armed_reg[ctx.op_proc] && !trig_reg[ctx.op_proc]
         && !ctx.sw_wr && !ctx.tlb_inval)
        |=> trig_reg[$past(ctx.op_proc)] && !armed_reg[$past(ctx.op_proc)];
    endproperty
    a_arm_trigger: assert property (p_arm_trigger)
        else $error("armed write did not trigger");

    property p_unarmed_clear;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ctx.op_wr && !armed_reg[ctx.op_proc] && !ctx.sw_wr)
        |=> !trig_reg[$past(ctx.op_proc)] && !armed_reg[$past(ctx.op_proc)];
    endproperty
    a_unarmed_clear: assert property (p_unarmed_clear)
        else $error("unarmed write left triggered set");

    property p_inval_disarm;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ctx.tlb_inval && armed_reg[0] && !trig_reg[0] && !ctx.sw_wr
         && !ctx.op_wr)
        |=> !armed_reg[0] && !trig_reg[0];
    endproperty
    a_inval_disarm: assert property (p_inval_disarm)
        else $error("invalidate did not disarm context");

    cover property (@(posedge clk_sys_i) disable iff (rst_i)
        ctx.tlb_inval && armed_reg[0] && !trig_reg[0]);
endmodule : icoi_ctx_regs
`default_nettype wire

/* File: rtl/icoi_top.sv */
// Decodes and issues inter-node cache flush and prefetch operations.
`timescale 1ns/1ps
`default_nettype none
module icoi_top
    import icoi_pkg::*;
(
    input  wire logic               clk_sys_i,
    input  wire logic               rst_i,
    input  wire logic               insn_valid_i,
    output logic                    insn_ready_o,
    input  wire logic [INSN_W-1:0]  insn_word_i,
    input  wire logic [GR_W-1:0]    insn_base_i,
    input  wire logic               insn_spec_i,
    input  wire logic               psw_xlat_en_i,
    input  wire logic               diag_op_enable_i,
    output logic                    xlat_req_o,
    output logic [SPACE_W-1:0]      xlat_space_sel_o,
    output logic [GR_W-1:0]         xlat_offset_o,
    output logic                    xlat_chk_rd_o,
    output logic                    xlat_chk_wr_o,
    input  wire logic               xlat_done_i,
    input  wire logic               xlat_miss_i,
    input  wire logic               xlat_rights_fail_i,
    input  wire logic [PADDR_W-1:0] xlat_paddr_i,
    output logic                    trap_illegal_o,
    output logic                    trap_tlb_miss_o,
    output logic                    trap_rights_o,
    output logic                    insn_defer_o,
    input  wire logic               csr_wr_i,
    output logic                    csr_ready_o,
    input  wire logic [PROC_W-1:0]  csr_proc_i,
    input  wire logic [1:0]         csr_sel_i,
    input  wire logic [GR_W-1:0]    csr_wdata_i,
    input  wire logic               csr_rd_i,
    output logic [GR_W-1:0]         csr_rdata_o,
    input  wire logic               tlb_inval_i,
    output logic                    coh_req_valid_o,
    input  wire logic               coh_req_ready_i,
    output logic [1:0]              coh_req_op_o,
    output logic [PADDR_W-1:0]      coh_req_addr_o
);
    typedef enum logic [1:0] {ST_IDLE, ST_XLAT, ST_ISSUE} icoi_state_t;

    function automatic logic [PADDR_W-1:0] line_align(
        input logic [PADDR_W-1:0] a);
        return {a[PADDR_W-1:LINE_OFS_W], {LINE_OFS_W{1'b0}}};
    endfunction : line_align

    function automatic icoi_op_t sel_to_op(input logic [1:0] sel);
        if (sel == CSR_SEL_FLUSH) begin
            return ICOI_OP_FLUSH;
        end else if (sel == CSR_SEL_PREF_SH) begin
            return ICOI_OP_PREF_SH;
        end else if (sel == CSR_SEL_PREF_EX) begin
            return ICOI_OP_PREF_EX;
        end else begin
            return ICOI_OP_NONE;
        end
    endfunction : sel_to_op

    icoi_link_if link ();

    icoi_insn_decode u_decode (
        .insn_i       (insn_word_i),
        .base_space_i (insn_base_i[BASE_SP_MSB:BASE_SP_LSB]),
        .dec          (link.dec_src)
    );

    icoi_ctx_regs u_ctx (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .ctx       (link.ctx_side)
    );

    icoi_state_t        state_reg;
    icoi_op_t           op_reg;
    logic [PADDR_W-1:0] paddr_reg;
    logic [SPACE_W-1:0] space_reg;
    logic [GR_W-1:0]    offset_reg;
    logic               chk_rd_reg;
    logic               chk_wr_reg;
    logic               trap_ill_reg;
    logic               trap_miss_reg;
    logic               trap_rights_reg;
    logic               defer_reg;
    logic               coh_valid_reg;
    icoi_op_t           coh_op_reg;
    logic [PADDR_W-1:0] coh_addr_reg;
    logic [GR_W-1:0]    rdata_reg;
    logic               insn_take;
    logic               insn_go;
    logic               insn_load;
    logic               csr_is_op;

    // No privilege input is consulted: any level may issue once enabled.
    assign insn_ready_o = (state_reg == ST_IDLE);
    assign insn_take    = insn_valid_i && insn_ready_o;
    assign insn_go      = insn_take && link.is_op && diag_op_enable_i
                          && link.hint_ok
                          && !(insn_spec_i && !link.spec_ok);
    assign insn_load    = (state_reg == ST_ISSUE) && !coh_valid_reg;
    assign xlat_req_o   = (state_reg == ST_XLAT);

    // The register path only takes an operation write while the request slot is idle,
    // so a held write back-pressures the core instead of being dropped.
    assign csr_is_op   = (csr_sel_i != CSR_SEL_CTX);
    assign csr_ready_o = !csr_is_op
                         || (!coh_valid_reg && state_reg != ST_ISSUE);

    assign link.sw_wr     = csr_wr_i && !csr_is_op;
    assign link.sw_proc   = csr_proc_i;
    assign link.sw_armed  = csr_wdata_i[CTX_ARMED_BIT];
    assign link.sw_trig   = csr_wdata_i[CTX_TRIG_BIT];
    assign link.op_wr     = csr_wr_i && csr_is_op && csr_ready_o;
    assign link.op_proc   = csr_proc_i;
    assign link.tlb_inval = tlb_inval_i;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (insn_go) begin
                        state_reg <= psw_xlat_en_i ? ST_XLAT : ST_ISSUE;
                    end
                end
                ST_XLAT: begin
                    if (xlat_done_i) begin
                        state_reg <= (xlat_miss_i || xlat_rights_fail_i)
                                     ? ST_IDLE : ST_ISSUE;
                    end
                end
                ST_ISSUE: begin
                    if (insn_load) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            op_reg     <= ICOI_OP_NONE;
            paddr_reg  <= '0;
            space_reg  <= '0;
            offset_reg <= '0;
            chk_rd_reg <= 1'b0;
            chk_wr_reg <= 1'b0;
        end else if (insn_go) begin
            op_reg     <= link.op;
            offset_reg <= insn_base_i;
            space_reg  <= link.space_sel;
            chk_rd_reg <= link.chk_rd;
            chk_wr_reg <= link.chk_wr;
            // With translation off the offset is the absolute address.
            paddr_reg  <= insn_base_i[PADDR_W-1:0];
        end else if (state_reg == ST_XLAT && xlat_done_i) begin
            paddr_reg  <= xlat_paddr_i;
        end
    end

    assign xlat_space_sel_o = space_reg;
    assign xlat_offset_o    = offset_reg;
    assign xlat_chk_rd_o    = chk_rd_reg;
    assign xlat_chk_wr_o    = chk_wr_reg;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            trap_ill_reg    <= 1'b0;
            trap_miss_reg   <= 1'b0;
            trap_rights_reg <= 1'b0;
            defer_reg       <= 1'b0;
        end else begin
            trap_ill_reg    <= insn_take && link.is_op
                               && (!diag_op_enable_i || !link.hint_ok);
            defer_reg       <= insn_take && link.is_op && diag_op_enable_i
                               && link.hint_ok && insn_spec_i
                               && !link.spec_ok;
            trap_miss_reg   <= (state_reg == ST_XLAT) && xlat_done_i
                               && xlat_miss_i;
            trap_rights_reg <= (state_reg == ST_XLAT) && xlat_done_i
                               && !xlat_miss_i && xlat_rights_fail_i;
        end
    end

    assign trap_illegal_o  = trap_ill_reg;
    assign trap_tlb_miss_o = trap_miss_reg;
    assign trap_rights_o   = trap_rights_reg;
    assign insn_defer_o    = defer_reg;

    // Low address bits are dropped since software aligns the base anyway.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            coh_valid_reg <= 1'b0;
            coh_op_reg    <= ICOI_OP_NONE;
            coh_addr_reg  <= '0;
        end else if (insn_load) begin
            coh_valid_reg <= 1'b1;
            coh_op_reg    <= op_reg;
            coh_addr_reg  <= line_align(paddr_reg);
        end else if (link.issue) begin
            coh_valid_reg <= 1'b1;
            coh_op_reg    <= sel_to_op(csr_sel_i);
            coh_addr_reg  <= line_align(csr_wdata_i[PADDR_W-1:0]);
        end else if (coh_valid_reg && coh_req_ready_i) begin
            coh_valid_reg <= 1'b0;
        end
    end

    assign coh_req_valid_o = coh_valid_reg;
    assign coh_req_op_o    = coh_op_reg;
    assign coh_req_addr_o  = coh_addr_reg;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rdata_reg <= '0;
        end else if (csr_rd_i) begin
            rdata_reg <= '0;
            rdata_reg[CTX_ARMED_BIT] <= link.armed[csr_proc_i];
            rdata_reg[CTX_TRIG_BIT]  <= link.trig[csr_proc_i];
        end
    end

    assign csr_rdata_o = rdata_reg;

    property p_illegal_when_disabled;
        @(posedge clk_sys_i) disable iff (rst_i)
        (insn_take && link.is_op && !diag_op_enable_i && !link.op_wr)
        |=> trap_illegal_o ##1 !coh_req_valid_o || $stable(coh_req_addr_o);
    endproperty
    a_illegal_when_disabled: assert property (p_illegal_when_disabled)
        else $error("disabled operation did not trap");

    property p_spec_refused;
        @(posedge clk_sys_i) disable iff (rst_i)
        (insn_take && link.is_op && diag_op_enable_i && link.hint_ok
         && insn_spec_i && !link.spec_ok)
        |=> insn_defer_o && state_reg == ST_IDLE;
    endproperty
    a_spec_refused: assert property (p_spec_refused)
        else $error("forbidden speculation was not deferred");

    property p_abs_issue;
        @(posedge clk_sys_i) disable iff (rst_i)
        (insn_go && !psw_xlat_en_i && !coh_valid_reg && !link.op_wr)
        |=> ##1 coh_req_valid_o && coh_req_addr_o
            == line_align($past(insn_base_i[PADDR_W-1:0], 2));
    endproperty
    a_abs_issue: assert property (p_abs_issue)
        else $error("absolute address not issued two cycles later");

    property p_miss_trap;
        @(posedge clk_sys_i) disable iff (rst_i)
        (state_reg == ST_XLAT && xlat_done_i && xlat_miss_i)
        |=> trap_tlb_miss_o && !trap_rights_o && state_reg == ST_IDLE;
    endproperty
    a_miss_trap: assert property (p_miss_trap)
        else $error("translation miss did not trap");

    property p_req_hold;
        @(posedge clk_sys_i) disable iff (rst_i)
        (coh_req_valid_o && !coh_req_ready_i)
        |=> coh_req_valid_o && $stable(coh_req_addr_o) && $stable(coh_req_op_o);
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("request changed while stalled");

    property p_csr_issue;
        @(posedge clk_sys_i) disable iff (rst_i)
        link.issue |=> coh_req_valid_o
            && coh_req_addr_o == line_align($past(csr_wdata_i[PADDR_W-1:0]));
    endproperty
    a_csr_issue: assert property (p_csr_issue)
        else $error("armed register write did not issue");

    property p_line_aligned;
        @(posedge clk_sys_i) disable iff (rst_i)
        coh_req_valid_o |-> coh_req_addr_o[LINE_OFS_W-1:0] == '0;
    endproperty
    a_line_aligned: assert property (p_line_aligned)
        else $error("request address not line aligned");

    cover property (@(posedge clk_sys_i) disable iff (rst_i)
        state_reg == ST_XLAT ##[1:20] insn_load);
    cover property (@(posedge clk_sys_i) disable iff (rst_i)
        link.issue && csr_sel_i == CSR_SEL_PREF_EX);
    cover property (@(posedge clk_sys_i) disable iff (rst_i)
        trap_illegal_o);
endmodule : icoi_top
`default_nettype wire

/* File: test/icoi_far_model.sv */
// Translation and coherence responder on the far side of the issue block.
`timescale 1ns/1ps
`default_nettype none
module icoi_far_model
    import icoi_pkg::*;
(
    input  wire logic             clk_sys_i,
    input  wire logic             xlat_req_i,
    input  wire logic [GR_W-1:0]  xlat_offset_i,
    output logic                  xlat_done_o = 0,
    output logic [PADDR_W-1:0]    xlat_paddr_o = 0,
    output logic                  coh_ready_o = 0
);
    // Answers stall at random; the address toggles while idle so that a
    // stale value is never mistaken for a fresh answer.
    always @(posedge clk_sys_i) begin
        xlat_done_o <= xlat_req_i && !xlat_done_o && 1'($urandom);
        xlat_paddr_o <= xlat_req_i ? xlat_offset_i[PADDR_W-1:0] : ~xlat_paddr_o;
        coh_ready_o <= 1'($urandom);
    end
endmodule : icoi_far_model
`default_nettype wire

/* File: test/tb_icoi_top.sv */
// Self-checking bench for the inter-node cache operation issue block.
`timescale 1ns/1ps
`default_nettype none
module tb_icoi_top;
    import icoi_pkg::*;
    logic clk_sys_i = 0, rst_i = 1, insn_valid_i = 0, insn_spec_i = 0;
    logic psw_xlat_en_i = 0, diag_op_enable_i = 0, csr_wr_i = 0, csr_rd_i = 0;
    logic tlb_inval_i = 0, xlat_miss_i = 0, xlat_rights_fail_i = 0;
    logic xlat_done_i, coh_req_ready_i, insn_ready_o, xlat_req_o;
    logic xlat_chk_rd_o, xlat_chk_wr_o, trap_illegal_o, trap_tlb_miss_o;
    logic trap_rights_o, insn_defer_o, csr_ready_o, coh_req_valid_o;
    logic [1:0] csr_proc_i = 0, csr_sel_i = 0, coh_req_op_o;
    logic [INSN_W-1:0] insn_word_i = 0;
    logic [GR_W-1:0] insn_base_i = 0, csr_wdata_i = 0, xlat_offset_o;
    logic [GR_W-1:0] csr_rdata_o, a;
    logic [PADDR_W-1:0] xlat_paddr_i, coh_req_addr_o;
    logic [SPACE_W-1:0] xlat_space_sel_o;
    int miscompares = 0, n_checks = 0, seen;
    always #4 clk_sys_i = ~clk_sys_i;
    icoi_top icoi_top_i (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .insn_valid_i(insn_valid_i),
        .insn_ready_o(insn_ready_o), .insn_word_i(insn_word_i),
        .insn_base_i(insn_base_i), .insn_spec_i(insn_spec_i),
        .psw_xlat_en_i(psw_xlat_en_i), .diag_op_enable_i(diag_op_enable_i),
        .xlat_req_o(xlat_req_o), .xlat_space_sel_o(xlat_space_sel_o),
        .xlat_offset_o(xlat_offset_o), .xlat_chk_rd_o(xlat_chk_rd_o),
        .xlat_chk_wr_o(xlat_chk_wr_o), .xlat_done_i(xlat_done_i),
        .xlat_miss_i(xlat_miss_i), .xlat_rights_fail_i(xlat_rights_fail_i),
        .xlat_paddr_i(xlat_paddr_i), .trap_illegal_o(trap_illegal_o),
        .trap_tlb_miss_o(trap_tlb_miss_o), .trap_rights_o(trap_rights_o),
        .insn_defer_o(insn_defer_o), .csr_wr_i(csr_wr_i),
        .csr_ready_o(csr_ready_o), .csr_proc_i(csr_proc_i),
        .csr_sel_i(csr_sel_i), .csr_wdata_i(csr_wdata_i), .csr_rd_i(csr_rd_i),
        .csr_rdata_o(csr_rdata_o), .tlb_inval_i(tlb_inval_i),
        .coh_req_valid_o(coh_req_valid_o), .coh_req_ready_i(coh_req_ready_i),
        .coh_req_op_o(coh_req_op_o), .coh_req_addr_o(coh_req_addr_o));
    icoi_far_model icoi_far_model_i (.clk_sys_i(clk_sys_i),
        .xlat_req_i(xlat_req_o), .xlat_offset_i(xlat_offset_o),
        .xlat_done_o(xlat_done_i), .xlat_paddr_o(xlat_paddr_i),
        .coh_ready_o(coh_req_ready_i));
    task automatic chk(string n, logic [63:0] got, logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, exp, got);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test
    task automatic step();
        @(posedge clk_sys_i);
        #1;
    endtask : step
    function automatic int want(int sub, int h, bit spec, bit en, int flt);
        if (sub != 2 && sub != 4 && sub != 6) return 0;
        if (!en || h == 0 || (sub != 2 && h == 1)) return 4;
        if (spec && h == 3) return 5;
        if (flt != 0) return flt;
        return sub / 2;
    endfunction : want
    // Outcome codes: 1..3 operation, 4 illegal trap, 5 deferred, 6 miss,
    // 7 rights fault, 0 nothing.
    task automatic watch(logic [PADDR_W-1:0] adr, bit must);
        seen = 0;
        for (int i = 0; i < 40 && seen == 0; i++) begin
            if (trap_illegal_o === 1'b1) seen = 4;
            else if (insn_defer_o === 1'b1) seen = 5;
            else if (trap_tlb_miss_o === 1'b1) seen = 6;
            else if (trap_rights_o === 1'b1) seen = 7;
            else if (coh_req_valid_o === 1'b1 && coh_req_ready_i === 1'b1) begin
                seen = coh_req_op_o;
                chk("coh_addr", coh_req_addr_o, adr & ~40'h1F);
            end
            step();
        end
        if (must && seen == 0) begin
            miscompares++;
            finish_test();
        end
    endtask : watch
    task automatic insn(int sub, int h, bit spec, bit en);
        logic [1:0] s, rw;
        logic [2:0] sp;
        int flt, e;
        bit go, xl;
        a = {$urandom, $urandom} & ~64'h1F;
        s = 2'($urandom);
        insn_word_i = {6'h01, 5'($urandom), 5'(sub), s, 2'h3, 2'(h), 10'h0};
        insn_base_i = a;
        insn_spec_i = spec;
        diag_op_enable_i = en;
        psw_xlat_en_i = 1'($urandom);
        // A miss may come with a rights fault too; the miss must win.
        flt = psw_xlat_en_i ? 6 + $urandom_range(3) : 0;
        if (flt > 7) flt = 0;
        xlat_miss_i = (flt == 6);
        xlat_rights_fail_i = (flt == 7) || (flt == 6 && 1'($urandom));
        e = want(sub, h, spec, en, flt);
        go = e inside {[1:3], 6, 7};
        xl = psw_xlat_en_i && go;
        sp = (s != 2'h0) ? {1'b0, s} : {1'b1, a[63:62]};
        rw = {h > 1, h == 3};
        insn_valid_i = 1;
        for (int i = 0; i < 20 && insn_ready_o !== 1'b1; i++) step();
        if (insn_ready_o !== 1'b1) begin
            miscompares++;
            finish_test();
        end
        step();
        insn_valid_i = 0;
        chk("state", {insn_ready_o, xlat_req_o}, {!go, xl});
        if (xl) begin
            chk("space", xlat_space_sel_o, sp);
            chk("rw", {xlat_chk_rd_o, xlat_chk_wr_o}, rw);
            chk("offset", xlat_offset_o, a);
        end
        watch(a[39:0], e != 0);
        chk("result", seen, e);
    endtask : insn
    // A held strobe lets the next write follow at the very next edge.
    task automatic csr(logic [1:0] p, logic [1:0] sel, logic [63:0] d,
                       bit hold);
        csr_proc_i = p;
        csr_sel_i = sel;
        csr_wdata_i = d;
        csr_wr_i = 1;
        for (int i = 0; i < 20 && csr_ready_o !== 1'b1; i++) step();
        if (csr_ready_o !== 1'b1) begin
            miscompares++;
            finish_test();
        end
        step();
        if (!hold) csr_wr_i = 0;
    endtask : csr
    task automatic ctx(logic [1:0] p, logic [63:0] exp);
        csr_proc_i = p;
        csr_rd_i = 1;
        step();
        csr_rd_i = 0;
        step();
        chk("ctx", csr_rdata_o, exp);
    endtask : ctx
    initial begin
        void'($urandom(32'h9F19DCBE));
        repeat (16) step();
        rst_i = 0;
        chk("reset", {insn_ready_o, csr_ready_o, coh_req_valid_o}, 3'h6);
        for (int k = 0; k < 24; k++) insn(2 + 2 * (k / 8), k % 4, k[2], 1);
        insn(3, 2, 0, 1);
        for (int k = 0; k < 20; k++) begin
            insn(2 + 2 * $urandom_range(2), $urandom_range(3),
                 1'($urandom), $urandom_range(3) != 0);
        end
        for (int p = 0; p < 4; p++) begin
            for (int s = 1; s < 4; s++) begin
                a = {$urandom, $urandom};
                csr(2'(p), 2'h0, 64'h8000_0000_0000_0000, 1);
                csr(2'(p), 2'(s), a, 0);
                chk("csr_ready", csr_ready_o, 0);
                watch(a[39:0], 1);
                chk("reg_op", seen, s);
                ctx(2'(p), 64'h4000_0000_0000_0000);
            end
        end
        csr(2'h0, 2'h1, a, 0);
        watch(a[39:0], 0);
        chk("unarmed", seen, 0);
        ctx(2'h0, 64'h0);
        csr(2'h1, 2'h0, 64'h8000_0000_0000_0000, 1);
        csr(2'h2, 2'h0, 64'hC000_0000_0000_0000, 0);
        tlb_inval_i = 1;
        step();
        tlb_inval_i = 0;
        ctx(2'h1, 64'h0);
        ctx(2'h2, 64'hC000_0000_0000_0000);
        ctx(2'h3, 64'h0);
        finish_test();
    end
endmodule : tb_icoi_top
`default_nettype wire
